// File: verilog/ccflg_pkg.sv
// condition code word package: field positions, widths, op codes, structs
// assumes a core that drives one operation request per clock
package ccflg_pkg;

  localparam int CCW_W = 16;
  localparam int ACC_W = 36;
  localparam int PC_W = 16;
  localparam int FETCH_W = 20;
  localparam int ACC_SPLIT = 16;
  localparam int BIT_STOP = 15;
  localparam int BIT_TOVF = 14;
  localparam int BIT_H = 13;
  localparam int BIT_XOVF = 12;
  localparam int BIT_N = 11;
  localparam int BIT_Z = 10;
  localparam int BIT_V = 9;
  localparam int BIT_C = 8;
  localparam int IPM_HI = 7;
  localparam int IPM_LO = 5;
  localparam int BIT_SAT = 4;
  localparam int PKX_HI = 3;
  localparam int PKX_LO = 0;
  localparam int ACC_TOP = 35;
  localparam int ACC_EXT = 31;
  localparam int NIB_CARRY = 4;
  localparam int BYTE_W = 8;
  localparam logic [15:0] CCW_RESET = 16'h80E0;
  // writable bits of the word: extension field is hardware only
  localparam logic [15:0] CCW_WMASK = 16'hFFF0;
  localparam logic [35:0] ACC_MAX_POS = 36'h7FFFFFFFF;
  localparam logic [35:0] ACC_MAX_NEG = 36'h800000000;

  typedef enum logic [2:0] {
    CCFLG_ALU_NONE,
    CCFLG_ALU_ADD,
    CCFLG_ALU_SUB,
    CCFLG_ALU_SHL,
    CCFLG_ALU_SHR,
    CCFLG_ALU_LOGIC
  } ccflg_alu_op_t;

  typedef enum logic [2:0] {
    CCFLG_CC_NONE,
    CCFLG_CC_LOAD,
    CCFLG_CC_SET,
    CCFLG_CC_CLR
  } ccflg_cc_op_t;

  typedef struct packed {
    ccflg_alu_op_t op;
    logic [15:0] a;
    logic [15:0] b;
    logic cin;
    logic bcd;
  } ccflg_alu_req_t;

  typedef struct packed {
    logic valid;
    logic [35:0] sum;
  } ccflg_mac_req_t;

  typedef struct packed {
    ccflg_cc_op_t op;
    logic [15:0] data;
  } ccflg_cc_req_t;

endpackage

// File: verilog/ccflg_mac_acc.sv
// 36-bit accumulator with overflow detection and saturating transfer
// assumes the core presents the raw extended-precision sum each cycle
`timescale 1ns/1ps
module ccflg_mac_acc
  import ccflg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // accumulate request
  input wire ccflg_mac_req_t mac_req,
  input wire logic [36:0] mac_full,
  // saturate control from the condition word
  input wire logic sat_mode,
  input wire logic top_ovf_flag,
  input wire logic ext_ovf_flag,
  // accumulator, transfer and overflow event outputs
  output logic [35:0] mac_acc_ff,
  output logic [35:0] acc_xfer_ff,
  output logic top_ovf_set,
  output logic ext_ovf_set
);

  logic sign_before_ff;

  ////////////////////////////////////////////////////////////////////////
  // overflow events: top carry differs from bit 35, or bits 35:31 mixed
  assign top_ovf_set = mac_req.valid &
                  (mac_full[ACC_W] != mac_full[ACC_TOP]);
  assign ext_ovf_set = mac_req.valid &
                  ~((&mac_full[ACC_TOP:ACC_EXT]) |
                    ~(|mac_full[ACC_TOP:ACC_EXT]));

  // accumulator store, 36 bits split at 16 into upper and lower parts
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      mac_acc_ff <= '0;
    else if (mac_req.valid)
      mac_acc_ff <= mac_req.sum;

  // sign bit before the overflow, held until a clean accumulate
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      sign_before_ff <= 1'b0;
    else if (mac_req.valid && !(top_ovf_flag || ext_ovf_flag))
      sign_before_ff <= mac_acc_ff[ACC_TOP];

  // transfer read value, clamped when saturating after overflow
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      acc_xfer_ff <= '0;
    else if (sat_mode && (top_ovf_flag || ext_ovf_flag))
      acc_xfer_ff <= sign_before_ff ? ACC_MAX_NEG : ACC_MAX_POS;
    else
      acc_xfer_ff <= mac_acc_ff;

endmodule // ccflg_mac_acc

// File: verilog/ccflg_fetch_ext.sv
// program counter extension field and 20-bit fetch address
// assumes the core reports increments and jump targets of the counter
`timescale 1ns/1ps
module ccflg_fetch_ext
  import ccflg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // program counter changes
  input wire logic pc_inc,
  input wire logic pc_jump,
  input wire logic [19:0] jump_target,
  // outputs
  output logic [3:0] program_counter_extension,
  output logic [19:0] fetch_addr_ff
);

  logic [19:0] nxt_fetch;

  // carry across 64K boundary falls into the extension naturally
  always_comb
  begin
    nxt_fetch = fetch_addr_ff;
    if (pc_jump)
      nxt_fetch = jump_target;
    else if (pc_inc)
      nxt_fetch = fetch_addr_ff + 20'h00001;
  end

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      fetch_addr_ff <= '0;
    else
      fetch_addr_ff <= nxt_fetch;

  assign program_counter_extension = fetch_addr_ff[FETCH_W-1:PC_W];

endmodule // ccflg_fetch_ext

// File: verilog/ccflg_flags.sv
// condition code word: result flags, mode bits, priority mask
// assumes one arithmetic, accumulate and word request per clock from the core
`timescale 1ns/1ps
// Operation
// - stop bit clear: stop instruction halts clocks; set: no-op
// - accumulate overflow into bit 35 sets the top overflow flag
// - decimal add carry out of bit 3 of either byte sets half carry
// - accumulate overflow into bit 31 sets the extension overflow flag
// - negative flag equals result most significant bit
// - zero flag set when all result bits are zero
// - overflow flag on signed two's complement overflow
// - carry flag on carry or borrow, and bit shifted out
// - interrupts below the three-bit priority mask are masked
// - saturate mode clamps transfers after overflow by old sign
// - fetch address is extension field prefixed to 16-bit counter
// - extension is hardware-updated on boundary carry or jump only
// - accumulator is 36 bits, upper 35:16, lower 15:0
// - dedicated word ops read, set, clear and transfer the word
module ccflg_flags
  import ccflg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // arithmetic request
  input wire ccflg_alu_req_t alu_req,
  // accumulate request and raw sum with extra carry bit
  input wire ccflg_mac_req_t mac_req,
  input wire logic [36:0] mac_full,
  // dedicated condition word operation
  input wire ccflg_cc_req_t cc_req,
  // stop instruction and interrupt request
  input wire logic stop_exec,
  input wire logic irq_valid,
  input wire logic [2:0] irq_level,
  // program counter changes
  input wire logic pc_inc,
  input wire logic pc_jump,
  input wire logic [19:0] jump_target,
  // results
  output logic [15:0] condition_code_word,
  output logic [15:0] alu_result_ff,
  output logic [35:0] mac_accumulator,
  output logic [35:0] acc_transfer_ff,
  output logic [19:0] fetch_addr_ff,
  output logic clock_halt_ff,
  output logic irq_accept
);

  logic stop_en_ff;
  logic top_ovf_ff;
  logic half_carry_ff;
  logic ext_ovf_ff;
  logic neg_ff;
  logic zero_ff;
  logic ovf_ff;
  logic carry_ff;
  logic [IPM_HI-IPM_LO:0] ipm_ff;
  logic sat_ff;
  logic [3:0] program_counter_extension;
  logic [16:0] nxt_sum;
  logic [15:0] nxt_res;
  logic nxt_c;
  logic nxt_v;
  logic nxt_h;
  logic nxt_n;
  logic nxt_z;
  logic alu_upd;
  logic top_ovf_set;
  logic ext_ovf_set;
  logic halt_req;
  logic [15:0] wr_val;

  // the 4-bit add of one nibble, used for both byte half carries
  function automatic logic nib_carry(input logic [3:0] x,
                                     input logic [3:0] y);
    logic [4:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[NIB_CARRY];
  endfunction

  // signed overflow of a two-operand sum from the three sign bits
  function automatic logic sign_ovf(input logic sa,
                                    input logic sb,
                                    input logic sr);
    return (sa == sb) && (sr != sa);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // arithmetic result and carry, overflow, half carry
  always_comb
  begin
    nxt_sum = '0;
    nxt_res = alu_req.a;
    nxt_c = carry_ff;
    nxt_v = 1'b0;
    nxt_h = half_carry_ff;
    alu_upd = 1'b1;
    unique case (alu_req.op)
      CCFLG_ALU_ADD:
      begin
        nxt_sum = {1'b0, alu_req.a} + {1'b0, alu_req.b} +
                  {16'h0000, alu_req.cin};
        nxt_res = nxt_sum[CCW_W-1:0];
        nxt_c = nxt_sum[CCW_W];
        nxt_v = sign_ovf(alu_req.a[CCW_W-1], alu_req.b[CCW_W-1],
                         nxt_res[CCW_W-1]);
        if (alu_req.bcd)
          nxt_h = nib_carry(alu_req.a[3:0], alu_req.b[3:0]) |
                  nib_carry(alu_req.a[BYTE_W+3:BYTE_W],
                            alu_req.b[BYTE_W+3:BYTE_W]);
      end
      CCFLG_ALU_SUB:
      begin
        nxt_sum = {1'b0, alu_req.a} - {1'b0, alu_req.b} -
                  {16'h0000, alu_req.cin};
        nxt_res = nxt_sum[CCW_W-1:0];
        nxt_c = nxt_sum[CCW_W];
        nxt_v = sign_ovf(alu_req.a[CCW_W-1], ~alu_req.b[CCW_W-1],
                         nxt_res[CCW_W-1]);
      end
      CCFLG_ALU_SHL:
      begin
        nxt_res = {alu_req.a[CCW_W-2:0], alu_req.cin};
        nxt_c = alu_req.a[CCW_W-1];
        nxt_v = alu_req.a[CCW_W-1] ^ alu_req.a[CCW_W-2];
      end
      CCFLG_ALU_SHR:
      begin
        nxt_res = {alu_req.cin, alu_req.a[CCW_W-1:1]};
        nxt_c = alu_req.a[0];
        nxt_v = alu_req.cin ^ alu_req.a[0];
      end
      CCFLG_ALU_LOGIC:
        nxt_res = alu_req.a;
      default:
        alu_upd = 1'b0;
    endcase
    nxt_n = nxt_res[CCW_W-1];
    nxt_z = ~(|nxt_res);
  end

  // result register
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      alu_result_ff <= '0;
    else if (alu_upd)
      alu_result_ff <= nxt_res;

  // value written by the dedicated word operations
  always_comb
  begin
    unique case (cc_req.op)
      CCFLG_CC_LOAD: wr_val = cc_req.data;
      CCFLG_CC_SET: wr_val = condition_code_word | cc_req.data;
      CCFLG_CC_CLR: wr_val = condition_code_word & ~cc_req.data;
      default: wr_val = condition_code_word;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // flag registers of the word; hardware flag events win over writes

  // stop enable bit, changed only by the word operations
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      stop_en_ff <= CCW_RESET[BIT_STOP];
    else
      stop_en_ff <= wr_val[BIT_STOP];

  // accumulator top overflow: the event wins over a clear
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      top_ovf_ff <= CCW_RESET[BIT_TOVF];
    else if (top_ovf_set)
      top_ovf_ff <= 1'b1;
    else
      top_ovf_ff <= wr_val[BIT_TOVF];

  // extension overflow: the event wins over a clear
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      ext_ovf_ff <= CCW_RESET[BIT_XOVF];
    else if (ext_ovf_set)
      ext_ovf_ff <= 1'b1;
    else
      ext_ovf_ff <= wr_val[BIT_XOVF];

  // half carry: an arithmetic update wins over a word write
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      half_carry_ff <= CCW_RESET[BIT_H];
    else if (alu_upd)
      half_carry_ff <= nxt_h;
    else
      half_carry_ff <= wr_val[BIT_H];

  // negative flag follows the result sign
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      neg_ff <= CCW_RESET[BIT_N];
    else if (alu_upd)
      neg_ff <= nxt_n;
    else
      neg_ff <= wr_val[BIT_N];

  // zero flag follows an all-zero result
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      zero_ff <= CCW_RESET[BIT_Z];
    else if (alu_upd)
      zero_ff <= nxt_z;
    else
      zero_ff <= wr_val[BIT_Z];

  // signed overflow flag
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      ovf_ff <= CCW_RESET[BIT_V];
    else if (alu_upd)
      ovf_ff <= nxt_v;
    else
      ovf_ff <= wr_val[BIT_V];

  // carry flag, also the bit moved out by a shift
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      carry_ff <= CCW_RESET[BIT_C];
    else if (alu_upd)
      carry_ff <= nxt_c;
    else
      carry_ff <= wr_val[BIT_C];

  // interrupt priority mask, written only by the word operations
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      ipm_ff <= CCW_RESET[IPM_HI:IPM_LO];
    else
      ipm_ff <= wr_val[IPM_HI:IPM_LO];

  // saturate mode bit, written only by the word operations
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      sat_ff <= CCW_RESET[BIT_SAT];
    else
      sat_ff <= wr_val[BIT_SAT];

  // assembled word; the extension field is owned by the fetch logic
  assign condition_code_word = {stop_en_ff, top_ovf_ff, half_carry_ff,
                                ext_ovf_ff, neg_ff, zero_ff, ovf_ff,
                                carry_ff, ipm_ff, sat_ff,
                                program_counter_extension};

  // stop request honoured only while the stop bit is clear
  assign halt_req = stop_exec & ~stop_en_ff;

  // halt level: set by an honoured stop, cleared by an accepted interrupt
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      clock_halt_ff <= 1'b0;
    else if (halt_req)
      clock_halt_ff <= 1'b1;
    else if (irq_accept)
      clock_halt_ff <= 1'b0;

  // interrupts below the mask are held off
  assign irq_accept = irq_valid &&
                      (irq_level >= condition_code_word[IPM_HI:IPM_LO]);

  ////////////////////////////////////////////////////////////////////////
  // accumulator and saturating transfer
  ccflg_mac_acc u_mac
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mac_req(mac_req),
    .mac_full(mac_full),
    .sat_mode(sat_ff),
    .top_ovf_flag(top_ovf_ff),
    .ext_ovf_flag(ext_ovf_ff),
    .mac_acc_ff(mac_accumulator),
    .acc_xfer_ff(acc_transfer_ff),
    .top_ovf_set(top_ovf_set),
    .ext_ovf_set(ext_ovf_set)
  );

  // fetch address and extension field
  ccflg_fetch_ext u_fetch
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pc_inc(pc_inc),
    .pc_jump(pc_jump),
    .jump_target(jump_target),
    .program_counter_extension(program_counter_extension),
    .fetch_addr_ff(fetch_addr_ff)
  );

endmodule // ccflg_flags

// File: sim/ccflg_flags_assertions.sv
// checker for the condition code word block
// sees only the ports of the flags top module
`timescale 1ns/1ps
module ccflg_flags_chk
  import ccflg_pkg::*;
(
  // clock, reset and requests
  input wire logic clk_sys,
  input wire logic rstn,
  input wire ccflg_alu_req_t alu_req,
  input wire ccflg_mac_req_t mac_req,
  input wire logic [36:0] mac_full,
  input wire logic stop_exec,
  input wire logic irq_valid,
  input wire logic [2:0] irq_level,
  input wire logic pc_inc,
  input wire logic pc_jump,
  // results
  input wire logic [15:0] condition_code_word,
  input wire logic [15:0] alu_result_ff,
  input wire logic [19:0] fetch_addr_ff,
  input wire logic clock_halt_ff,
  input wire logic irq_accept
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // reference sum and signed overflow of a binary add
  wire logic [16:0] add_sum;
  wire logic add_ovf;
  wire logic alu_go;
  assign add_sum = {1'b0, alu_req.a} + {1'b0, alu_req.b} + 17'(alu_req.cin);
  assign add_ovf = (alu_req.a[15] == alu_req.b[15]) &&
    (add_sum[15] != alu_req.a[15]);
  assign alu_go = alu_req.op != CCFLG_ALU_NONE;
  chk_neg_flag: assert property (alu_go |=>
    condition_code_word[BIT_N] == alu_result_ff[15]) else $error("N wrong");
  chk_zero_flag: assert property (alu_go |=>
    condition_code_word[BIT_Z] == (alu_result_ff == 16'h0000))
    else $error("Z wrong");
  chk_add_carry: assert property (alu_req.op == CCFLG_ALU_ADD &&
    !alu_req.bcd |=> condition_code_word[BIT_C] == $past(add_sum[16]) &&
    alu_result_ff == $past(add_sum[15:0])) else $error("carry wrong");
  chk_add_ovf: assert property (alu_req.op == CCFLG_ALU_ADD &&
    !alu_req.bcd |=> condition_code_word[BIT_V] == $past(add_ovf))
    else $error("V wrong");
  chk_top_ovf: assert property (mac_req.valid &&
    mac_full[36] != mac_full[35] |=> condition_code_word[BIT_TOVF])
    else $error("top overflow not set");
  chk_ext_ovf: assert property (mac_req.valid &&
    !(mac_full[35:31] inside {5'h00, 5'h1F}) |=> condition_code_word[BIT_XOVF])
    else $error("extension overflow not set");
  chk_stop_halt: assert property (stop_exec &&
    !condition_code_word[BIT_STOP] |=> clock_halt_ff) else $error("no halt");
  chk_stop_nop: assert property (stop_exec &&
    condition_code_word[BIT_STOP] && !clock_halt_ff |=> !clock_halt_ff)
    else $error("halt on no-op stop");
  chk_irq_mask: assert property (irq_valid |-> irq_accept ==
    (irq_level >= condition_code_word[IPM_HI:IPM_LO])) else $error("mask");
  chk_fetch_ext: assert property (
    condition_code_word[PKX_HI:PKX_LO] == fetch_addr_ff[19:16])
    else $error("extension mismatch");
  chk_ext_hold: assert property (!pc_inc && !pc_jump |=>
    $stable(fetch_addr_ff)) else $error("fetch moved");
endmodule // ccflg_flags_chk
////////////////////////////////////////////////////////////////////////////
bind ccflg_flags ccflg_flags_chk u_chk (.clk_sys, .rstn, .alu_req, .mac_req,
  .mac_full, .stop_exec, .irq_valid, .irq_level, .pc_inc, .pc_jump,
  .condition_code_word, .alu_result_ff, .fetch_addr_ff, .clock_halt_ff,
  .irq_accept);

// File: sim/tb.sv
// self-checking bench for the condition code word block
// drives every input at the falling edge of a 50 MHz clock
`timescale 1ns/1ps
module tb
  import ccflg_pkg::*;
;
  typedef struct packed {
    ccflg_alu_op_t op;
    logic [15:0] a;
    logic [15:0] b;
    logic cin;
    logic [15:0] res;
    logic [3:0] nzvc;
  } ccflg_row_t;
  logic clk_sys, rstn, stop_exec, irq_valid, pc_inc, pc_jump;
  ccflg_alu_req_t alu_req;
  ccflg_mac_req_t mac_req;
  ccflg_cc_req_t cc_req;
  logic [36:0] mac_full;
  logic [2:0] irq_level;
  logic [19:0] jump_target, fetch_addr_ff;
  logic [15:0] condition_code_word, alu_result_ff;
  logic [35:0] mac_accumulator, acc_transfer_ff;
  logic clock_halt_ff, irq_accept;
  int failures, check_count;
  ccflg_row_t rows [8] = '{
    '{CCFLG_ALU_ADD, 16'h7FFF, 16'h0001, 1'b0, 16'h8000, 4'hA},
    '{CCFLG_ALU_ADD, 16'hFFFF, 16'h0001, 1'b0, 16'h0000, 4'h5},
    '{CCFLG_ALU_LOGIC, 16'h1234, 16'h0000, 1'b0, 16'h1234, 4'h1},
    '{CCFLG_ALU_SUB, 16'h0000, 16'h0001, 1'b0, 16'hFFFF, 4'h9},
    '{CCFLG_ALU_SUB, 16'h8000, 16'h0001, 1'b0, 16'h7FFF, 4'h2},
    '{CCFLG_ALU_SHL, 16'h8001, 16'h0000, 1'b0, 16'h0002, 4'h3},
    '{CCFLG_ALU_SHR, 16'h0001, 16'h0000, 1'b0, 16'h0000, 4'h7},
    '{CCFLG_ALU_ADD, 16'h0001, 16'h0001, 1'b1, 16'h0003, 4'h0}};
  ccflg_flags u_dut (.clk_sys, .rstn, .alu_req, .mac_req, .mac_full,
    .cc_req, .stop_exec, .irq_valid, .irq_level, .pc_inc, .pc_jump,
    .jump_target, .condition_code_word, .alu_result_ff, .mac_accumulator,
    .acc_transfer_ff, .fetch_addr_ff, .clock_halt_ff, .irq_accept);
  //////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic check(string name, logic [35:0] seen, logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one word operation for one cycle
  task automatic cc(ccflg_cc_op_t op, logic [15:0] d);
    cc_req = '{op, d};
    @(negedge clk_sys);
    cc_req = '{CCFLG_CC_NONE, 16'h0000};
    @(negedge clk_sys);
  endtask
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // free-running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    {rstn, stop_exec, irq_valid, pc_inc, pc_jump} = 5'h00;
    {alu_req, mac_req, cc_req, mac_full, irq_level, jump_target} = '0;
    repeat (2) @(negedge clk_sys);
    check("reset word", condition_code_word, CCW_RESET);
    rstn = 1'b1;
    foreach (rows[i])
    begin
      alu_req = '{rows[i].op, rows[i].a, rows[i].b, rows[i].cin, 1'b0};
      @(negedge clk_sys);
      check("result", alu_result_ff, rows[i].res);
      check("nzvc", condition_code_word[11:8], rows[i].nzvc);
    end
    alu_req = '0;
    $display("arithmetic rows done");
    for (int i = 0; i < 2; i++)
    begin
      cc(CCFLG_CC_CLR, 16'h2000);
      check("half clear", condition_code_word[BIT_H], 1'b0);
      alu_req = '{CCFLG_ALU_ADD, 16'h000F << (8 * i), 16'h0001 << (8 * i),
        1'b0, 1'b1};
      @(negedge clk_sys);
      alu_req = '0;
      check("half carry", condition_code_word[BIT_H], 1'b1);
    end
    cc(CCFLG_CC_LOAD, 16'h000F);
    check("load", condition_code_word, 16'h0000);
    cc(CCFLG_CC_SET, 16'h0070);
    check("set", condition_code_word, 16'h0070);
    cc(CCFLG_CC_CLR, 16'h0020);
    check("clear", condition_code_word, 16'h0050);
    irq_valid = 1'b1;
    for (int l = 0; l < 8; l++)
    begin
      irq_level = 3'(l);
      @(negedge clk_sys);
      check("irq accept", irq_accept, l >= 2);
    end
    irq_valid = 1'b0;
    $display("word and mask tests done");
    stop_exec = 1'b1;
    @(negedge clk_sys);
    stop_exec = 1'b0;
    check("halt", clock_halt_ff, 1'b1);
    irq_valid = 1'b1;
    @(negedge clk_sys);
    irq_valid = 1'b0;
    check("wake", clock_halt_ff, 1'b0);
    cc(CCFLG_CC_SET, 16'h8000);
    stop_exec = 1'b1;
    @(negedge clk_sys);
    stop_exec = 1'b0;
    check("stop no-op", clock_halt_ff, 1'b0);
    $display("stop tests done");
    mac_req = '{1'b1, 36'h080000000};
    mac_full = 37'h0080000000;
    @(negedge clk_sys);
    mac_req.valid = 1'b0;
    check("ovf", condition_code_word[BIT_TOVF:BIT_XOVF], 3'h1);
    check("acc", mac_accumulator, 36'h080000000);
    @(negedge clk_sys);
    check("saturate", acc_transfer_ff, ACC_MAX_POS);
    cc(CCFLG_CC_CLR, 16'h5010);
    @(negedge clk_sys);
    check("raw xfer", acc_transfer_ff, 36'h080000000);
    mac_req = '{1'b1, 36'h800000000};
    mac_full = 37'h0800000000;
    @(negedge clk_sys);
    mac_req.valid = 1'b0;
    check("top ovf", condition_code_word[BIT_TOVF], 1'b1);
    $display("accumulator tests done");
    pc_jump = 1'b1;
    jump_target = 20'h1FFFF;
    @(negedge clk_sys);
    pc_jump = 1'b0;
    check("jump ext", condition_code_word[3:0], 4'h1);
    check("jump", fetch_addr_ff, 20'h1FFFF);
    pc_inc = 1'b1;
    @(negedge clk_sys);
    pc_inc = 1'b0;
    check("page ext", condition_code_word[3:0], 4'h2);
    check("carry page", fetch_addr_ff, 20'h20000);
    rstn = 1'b0;
    @(negedge clk_sys);
    check("rereset", condition_code_word, CCW_RESET);
    rstn = 1'b1;
    $display("fetch and reset tests done");
    print_verdict();
  end
endmodule // tb
